/* sensor_cmd_pkg.sv */
// constants, codes and types of the serial command port
// assumes a byte-wide uart on the same clock outside the command port
package sensor_cmd_pkg;

   // ------------------------------------------------------------------
   // characters and telegram lengths
   // ------------------------------------------------------------------
   localparam logic [7:0]  CH_CR      = 8'h0D;
   localparam logic [7:0]  CH_BANG    = 8'h21;
   localparam logic [7:0]  CH_ZERO    = 8'h30;
   localparam logic [7:0]  CH_NINE    = 8'h39;
   localparam logic [3:0]  LEN_QUERY  = 4'h4;
   localparam logic [3:0]  LEN_PARAM  = 4'h9;
   localparam logic [3:0]  LAST_CHAR  = 4'h9;

   // ------------------------------------------------------------------
   // command codes, two ascii letters
   // ------------------------------------------------------------------
   localparam logic [15:0] CMD_DM     = 16'h444D;
   localparam logic [15:0] CMD_RD     = 16'h5244;
   localparam logic [15:0] CMD_ID     = 16'h4944;
   localparam logic [15:0] CMD_KY     = 16'h4B59;
   localparam logic [15:0] CMD_TR     = 16'h5452;
   localparam logic [15:0] CMD_TT     = 16'h5454;
   localparam logic [15:0] CMD_XI     = 16'h5849;
   localparam logic [15:0] CMD_AA     = 16'h4141;
   localparam logic [15:0] CMD_AB     = 16'h4142;
   localparam logic [15:0] CMD_BR     = 16'h4252;
   localparam logic [15:0] CMD_AV     = 16'h4156;
   localparam logic [15:0] CMD_CE     = 16'h4345;

   // ------------------------------------------------------------------
   // modes, levels, error values (values are five bcd digits)
   // ------------------------------------------------------------------
   localparam logic [1:0]  DM_HALF_BUS = 2'h0;
   localparam logic [1:0]  DM_FULL_BUS = 2'h1;
   localparam logic [1:0]  DM_FULL_P2P = 2'h2;
   typedef enum logic [1:0] {
      LVL_ENQUIRY = 2'b00,
      LVL_USER    = 2'b01,
      LVL_CONFIG  = 2'b10
   } access_level_t;
   localparam logic [19:0] ERR_ACCESS   = 20'h0_0008;
   localparam logic [19:0] ERR_RANGE    = 20'h0_0016;
   localparam logic [19:0] ERR_CONFLICT = 20'h0_0032;
   localparam logic [19:0] KEY_ENQUIRY  = 20'h0_0000;
   localparam logic [19:0] KEY_USER     = 20'h0_0001;
   localparam logic [19:0] MAX_DM       = 20'h0_0002;
   localparam logic [19:0] MAX_ID       = 20'h0_0099;

   // ------------------------------------------------------------------
   // values after reset
   // ------------------------------------------------------------------
   localparam logic [7:0]  RST_ID  = 8'h00;
   localparam logic [1:0]  RST_DM  = DM_FULL_BUS;
   localparam logic [19:0] RST_VAL = 20'h0_0000;
   localparam logic [19:0] RST_BR  = 20'h0_0005;

   // ------------------------------------------------------------------
   // parameter store entries
   // ------------------------------------------------------------------
   localparam int          MEM_DEPTH = 2;
   localparam logic [0:0]  MEM_BR    = 1'h0;
   localparam logic [0:0]  MEM_AV    = 1'h1;

   // ------------------------------------------------------------------
   // timing
   // ------------------------------------------------------------------
   localparam int CLK_HZ     = 50_000_000;
   localparam int MS_CYCLES  = CLK_HZ / 1000;
   localparam int MINUTE_S   = 60;
   localparam int MINUTE_MS  = MINUTE_S * 1000;

   typedef enum logic [2:0] {
      ST_IDLE = 3'b000,
      ST_EVAL = 3'b001,
      ST_EXEC = 3'b010,
      ST_WAIT = 3'b011,
      ST_SEND = 3'b100
   } cmd_state_t;

endpackage : sensor_cmd_pkg

/* param_store_if.sv */
// port between the command parser and its parameter store
// assumes both ends run on mclk_i
`timescale 1ns/1ps
`default_nettype none
interface param_store_if #(
   parameter int AW = 1,
   parameter int DW = 20
);
   logic [AW-1:0] addr;
   logic          we;
   logic [DW-1:0] wdata;
   logic [DW-1:0] rdata;
   modport ctrl (output addr, output we, output wdata, input rdata);
   modport store (input addr, input we, input wdata, output rdata);
endinterface : param_store_if
`default_nettype wire

/* param_store.sv */
// small parameter store with registered read data
// assumes one clock and a synchronous reset to the default values
`timescale 1ns/1ps
`default_nettype none
module param_store
   import sensor_cmd_pkg::*;
#(
   parameter int DEPTH = MEM_DEPTH,
   parameter int DW    = 20
) (
   input  wire logic   mclk_i,
   input  wire logic   rst_i,
   param_store_if.store bus
);
   logic [DW-1:0] mem_q [DEPTH];

   // entries reset so that a read before any write returns the default
   for (genvar i = 0; i < DEPTH; i++) begin : g_entry
      always_ff @(posedge mclk_i) begin
         if (rst_i) begin
            mem_q[i] <= (i == int'(MEM_BR)) ? RST_BR : RST_VAL;
         end else if (bus.we && int'(bus.addr) == i) begin
            mem_q[i] <= bus.wdata;
         end
      end
   end

   always_ff @(posedge mclk_i) begin
      bus.rdata <= mem_q[bus.addr];
   end
endmodule : param_store
`default_nettype wire

/* sensor_serial_command_port.sv */
// serial command interpreter: parses telegrams, replies after delay
// assumes a byte uart on mclk_i; ext_id_i and heat_req_i are raw pins
`timescale 1ns/1ps
`default_nettype none
module sensor_serial_command_port
   import sensor_cmd_pkg::*;
#(
   parameter int          MS_DIV       = MS_CYCLES,
   parameter int          MINUTE_TICKS = MINUTE_MS,
   parameter logic [19:0] CONFIG_KEY   = 20'h1_2345
) (
   input  wire logic        mclk_i,
   input  wire logic        rst_i,
   input  wire logic [7:0]  rx_data_i,
   input  wire logic        rx_valid_i,
   output logic      [7:0]  tx_data_o,
   output logic             tx_valid_o,
   input  wire logic        tx_ready_i,
   input  wire logic        tx_busy_i,
   input  wire logic        tel_busy_i,
   input  wire logic [7:0]  ext_id_i,
   input  wire logic        heat_req_i,
   output logic             driver_en_o,
   output logic             full_duplex_o,
   output logic      [1:0]  duplex_select_o,
   output logic      [7:0]  station_id_o,
   output access_level_t    access_level_o,
   output logic             periodic_en_o,
   output logic             data_tel_req_o,
   output logic      [19:0] data_tel_num_o,
   output logic             analog_rx_en_o,
   output logic             heat_ctrl_o
);

   // ------------------------------------------------------------------
   // helpers
   // ------------------------------------------------------------------
   function automatic logic is_digit(input logic [7:0] c);
      return (c >= CH_ZERO) && (c <= CH_NINE);
   endfunction : is_digit

   function automatic logic [16:0] bcd_to_bin(input logic [19:0] b);
      logic [16:0] r;
      r = 17'(b[19:16]) * 17'd10000 + 17'(b[15:12]) * 17'd1000
        + 17'(b[11:8]) * 17'd100 + 17'(b[7:4]) * 17'd10 + 17'(b[3:0]);
      return r;
   endfunction : bcd_to_bin

   // ------------------------------------------------------------------
   // state
   // ------------------------------------------------------------------
   cmd_state_t     state_q;
   logic [71:0]    buf_q;
   logic [3:0]     cnt_q;
   logic [15:0]    code_q;
   logic [19:0]    val_q;
   logic           has_val_q;
   logic           bad_q;
   logic [1:0]     boot_q;
   logic [7:0]     id_q;
   logic [1:0]     dm_q;
   logic [19:0]    rd_q;
   logic [19:0]    tt_q;
   logic [19:0]    xi_q;
   logic [19:0]    aa_q;
   logic [19:0]    ab_q;
   logic [19:0]    ky_q;
   access_level_t  level_q;
   logic [15:0]    rep_code_q;
   logic [19:0]    rep_val_q;
   logic           rep_tel_q;
   logic [16:0]    delay_q;
   logic [3:0]     idx_q;
   logic [15:0]    ms_cnt_q;
   logic           ms_tick_q;
   logic [16:0]    min_cnt_q;
   logic           minute_done_q;
   logic [7:0]     ext_meta_q;
   logic [7:0]     ext_sync_q;
   logic           heat_meta_q;
   logic           heat_sync_q;

   param_store_if #(.AW(1), .DW(20)) store_bus ();

   param_store #(.DEPTH(MEM_DEPTH), .DW(20)) u_store (
      .mclk_i (mclk_i),
      .rst_i  (rst_i),
      .bus    (store_bus.store)
   );

   // ------------------------------------------------------------------
   // receive field decode
   // ------------------------------------------------------------------
   wire        is_query   = (cnt_q == LEN_QUERY);
   wire        is_param   = (cnt_q == LEN_PARAM);
   wire [15:0] id_chars   = is_param ? buf_q[71:56] : buf_q[31:16];
   wire [15:0] code_chars = is_param ? buf_q[55:40] : buf_q[15:0];
   wire [19:0] par_bcd    = {buf_q[35:32], buf_q[27:24], buf_q[19:16],
                             buf_q[11:8], buf_q[3:0]};
   wire        par_digits = is_digit(buf_q[39:32]) && is_digit(buf_q[31:24])
                         && is_digit(buf_q[23:16]) && is_digit(buf_q[15:8])
                         && is_digit(buf_q[7:0]);
   wire        id_digits  = is_digit(id_chars[15:8]) && is_digit(id_chars[7:0]);
   wire [7:0]  id_bcd     = {id_chars[11:8], id_chars[3:0]};
   wire        id_match   = id_digits && (id_bcd == id_q);
   wire        frame_ok   = (is_query || is_param) && id_match;
   wire        half_mode  = (dm_q == DM_HALF_BUS);
   wire        p2p_mode   = (dm_q == DM_FULL_P2P);
   // own echo on the shared pair is not a command
   wire        rx_take    = rx_valid_i && (state_q == ST_IDLE)
                         && !(half_mode && driver_en_o);
   wire        rx_cr      = rx_take && (rx_data_i == CH_CR);

   // ------------------------------------------------------------------
   // command decode and checks
   // ------------------------------------------------------------------
   wire c_dm = (code_q == CMD_DM);
   wire c_rd = (code_q == CMD_RD);
   wire c_id = (code_q == CMD_ID);
   wire c_ky = (code_q == CMD_KY);
   wire c_tr = (code_q == CMD_TR);
   wire c_tt = (code_q == CMD_TT);
   wire c_xi = (code_q == CMD_XI);
   wire c_aa = (code_q == CMD_AA);
   wire c_ab = (code_q == CMD_AB);
   wire c_br = (code_q == CMD_BR);
   wire c_av = (code_q == CMD_AV);
   wire known = c_dm | c_rd | c_id | c_ky | c_tr | c_tt | c_xi | c_aa
              | c_ab | c_br | c_av;
   wire nonzero = (val_q != RST_VAL);
   wire half_only_set = (xi_q != RST_VAL) || (aa_q != RST_VAL)
                     || (ab_q != RST_VAL);
   // key and telegram requests are enquiry level; other writes need user
   wire access_level_t req_lvl = (has_val_q && !c_ky && !c_tr)
                               ? LVL_USER : LVL_ENQUIRY;
   wire err_access = (level_q < req_lvl);
   wire ky_bad = c_ky && !(val_q == KEY_ENQUIRY || val_q == KEY_USER
                          || val_q == CONFIG_KEY);
   wire err_range = has_val_q && (bad_q || (c_dm && val_q > MAX_DM)
                 || (c_id && val_q > MAX_ID) || ky_bad);
   wire err_conflict = has_val_q && nonzero
                    && (((c_xi || c_aa || c_ab) && !half_mode)
                        || (c_dm && half_only_set));
   wire [19:0] err_val = err_access   ? ERR_ACCESS :
                         err_range    ? ERR_RANGE  : ERR_CONFLICT;
   wire any_err = err_access || err_range || err_conflict;
   wire do_write = has_val_q && !any_err;
   wire [19:0] cur_val = c_dm ? {18'h0_0000, dm_q} :
                         c_rd ? rd_q :
                         c_id ? {12'h000, id_q} :
                         c_ky ? ky_q :
                         c_tt ? tt_q :
                         c_xi ? xi_q :
                         c_aa ? aa_q :
                         c_ab ? ab_q : store_bus.rdata;
   wire exec_now = (state_q == ST_EXEC);

   assign store_bus.addr  = c_av ? MEM_AV : MEM_BR;
   assign store_bus.we    = exec_now && do_write && (c_br || c_av);
   assign store_bus.wdata = val_q;

   // ------------------------------------------------------------------
   // reply character select
   // ------------------------------------------------------------------
   wire [3:0]  next_idx = idx_q + 4'h1;
   wire        tx_fire  = tx_valid_o && tx_ready_i;
   wire        wait_end = (state_q == ST_WAIT) && (delay_q == 17'h0_0000);
   wire        to_send  = wait_end && !rep_tel_q;

   function automatic logic [7:0] char_at(input logic [3:0] i,
      input logic [7:0] id, input logic [15:0] cd, input logic [19:0] v);
      logic [7:0] c;
      c = CH_BANG;
      unique case (i)
         4'h0: c = CH_BANG;
         4'h1: c = CH_ZERO | {4'h0, id[7:4]};
         4'h2: c = CH_ZERO | {4'h0, id[3:0]};
         4'h3: c = cd[15:8];
         4'h4: c = cd[7:0];
         4'h5: c = CH_ZERO | {4'h0, v[19:16]};
         4'h6: c = CH_ZERO | {4'h0, v[15:12]};
         4'h7: c = CH_ZERO | {4'h0, v[11:8]};
         4'h8: c = CH_ZERO | {4'h0, v[7:4]};
         4'h9: c = CH_ZERO | {4'h0, v[3:0]};
         default: c = CH_BANG;
      endcase
      return c;
   endfunction : char_at

   // ------------------------------------------------------------------
   // timebase and pin synchronisers
   // ------------------------------------------------------------------
   always_ff @(posedge mclk_i) begin
      if (rst_i || ms_cnt_q == 16'(MS_DIV - 1)) begin
         ms_cnt_q  <= 16'h0000;
         ms_tick_q <= !rst_i;
      end else begin
         ms_cnt_q  <= ms_cnt_q + 16'h0001;
         ms_tick_q <= 1'b0;
      end
   end

   always_ff @(posedge mclk_i) begin
      ext_meta_q  <= ext_id_i;
      ext_sync_q  <= ext_meta_q;
      heat_meta_q <= heat_req_i;
      heat_sync_q <= heat_meta_q;
      heat_ctrl_o <= !rst_i && heat_sync_q;
   end

   // one minute hold-off, restarted by reset or a periodic setting
   always_ff @(posedge mclk_i) begin
      if (rst_i || (exec_now && do_write && c_tt)) begin
         min_cnt_q     <= 17'h0_0000;
         minute_done_q <= 1'b0;
      end else if (ms_tick_q && !minute_done_q) begin
         min_cnt_q     <= min_cnt_q + 17'h0_0001;
         minute_done_q <= (min_cnt_q == 17'(MINUTE_TICKS - 1));
      end
   end

   // ------------------------------------------------------------------
   // line driver and mode outputs
   // ------------------------------------------------------------------
   always_ff @(posedge mclk_i) begin
      if (rst_i) begin
         driver_en_o    <= 1'b0;
         periodic_en_o  <= 1'b0;
         analog_rx_en_o <= 1'b0;
      end else begin
         driver_en_o    <= p2p_mode || to_send || (state_q == ST_SEND)
                        || tx_busy_i || tel_busy_i;
         periodic_en_o  <= (tt_q != RST_VAL)
                        && (!half_mode || minute_done_q);
         analog_rx_en_o <= half_mode && ((aa_q != RST_VAL)
                        || (ab_q != RST_VAL));
      end
   end

   assign duplex_select_o = dm_q;
   assign station_id_o    = id_q;
   assign access_level_o  = level_q;

   // ------------------------------------------------------------------
   // receive buffer
   // ------------------------------------------------------------------
   always_ff @(posedge mclk_i) begin
      if (rst_i || rx_cr) begin
         buf_q <= 72'h0;
         cnt_q <= 4'h0;
      end else if (rx_take && cnt_q <= LEN_PARAM) begin
         // overlong input stays counted and is dropped at the return
         buf_q <= {buf_q[63:0], rx_data_i};
         cnt_q <= cnt_q + 4'h1;
      end
   end

   // ------------------------------------------------------------------
   // settings
   // ------------------------------------------------------------------
   always_ff @(posedge mclk_i) begin
      if (rst_i) begin
         id_q    <= RST_ID;
         dm_q    <= RST_DM;
         full_duplex_o <= 1'b1;
         rd_q    <= RST_VAL;
         tt_q    <= RST_VAL;
         xi_q    <= RST_VAL;
         aa_q    <= RST_VAL;
         ab_q    <= RST_VAL;
         ky_q    <= KEY_ENQUIRY;
         level_q <= LVL_ENQUIRY;
      end else if (exec_now && do_write) begin
         if (c_dm) dm_q <= val_q[1:0];
         // flag moves in the same cycle as the selection it mirrors
         if (c_dm) full_duplex_o <= (val_q[1:0] != DM_HALF_BUS);
         if (c_rd) rd_q <= val_q;
         if (c_tt) tt_q <= val_q;
         if (c_aa) aa_q <= val_q;
         if (c_ab) ab_q <= val_q;
         if (c_xi) xi_q <= val_q;
         if (c_id) id_q <= val_q[7:0];
         // pin read-in only reaches here in half duplex
         if (c_xi && nonzero) id_q <= ext_sync_q;
         if (c_ky) begin
            ky_q    <= val_q;
            level_q <= (val_q == KEY_ENQUIRY) ? LVL_ENQUIRY :
                       (val_q == KEY_USER)    ? LVL_USER : LVL_CONFIG;
         end
      end
   end

   // ------------------------------------------------------------------
   // command sequencer
   // ------------------------------------------------------------------
   always_ff @(posedge mclk_i) begin
      if (rst_i) begin
         state_q        <= ST_IDLE;
         boot_q         <= 2'h0;
         code_q         <= CMD_BR;
         val_q          <= RST_VAL;
         has_val_q      <= 1'b0;
         bad_q          <= 1'b0;
         rep_code_q     <= CMD_BR;
         rep_val_q      <= RST_VAL;
         rep_tel_q      <= 1'b0;
         delay_q        <= 17'h0_0000;
         idx_q          <= 4'h0;
         tx_data_o      <= CH_BANG;
         tx_valid_o     <= 1'b0;
         data_tel_req_o <= 1'b0;
         data_tel_num_o <= RST_VAL;
      end else begin
         data_tel_req_o <= 1'b0;
         unique case (state_q)
            ST_IDLE: begin
               if (boot_q != 2'h2) begin
                  // start-up announcement of baud and duplex settings
                  code_q    <= (boot_q == 2'h0) ? CMD_BR : CMD_DM;
                  has_val_q <= 1'b0;
                  bad_q     <= 1'b0;
                  boot_q    <= boot_q + 2'h1;
                  state_q   <= ST_EVAL;
               end else if (rx_cr && frame_ok) begin
                  code_q    <= code_chars;
                  val_q     <= par_bcd;
                  has_val_q <= is_param;
                  bad_q     <= is_param && !par_digits;
                  state_q   <= ST_EVAL;
               end
            end
            ST_EVAL: begin
               state_q <= ST_EXEC;
            end
            ST_EXEC: begin
               rep_tel_q  <= (c_tr || c_tt) && !any_err;
               rep_code_q <= any_err ? CMD_CE : code_q;
               rep_val_q  <= any_err ? err_val :
                             has_val_q ? val_q : cur_val;
               data_tel_num_o <= has_val_q ? val_q : tt_q;
               delay_q    <= bcd_to_bin(rd_q);
               state_q    <= known ? ST_WAIT : ST_IDLE;
            end
            ST_WAIT: begin
               if (wait_end) begin
                  data_tel_req_o <= rep_tel_q;
                  idx_q          <= 4'h0;
                  tx_data_o      <= char_at(4'h0, id_q, rep_code_q,
                                            rep_val_q);
                  tx_valid_o     <= !rep_tel_q;
                  state_q        <= rep_tel_q ? ST_IDLE : ST_SEND;
               end else if (ms_tick_q) begin
                  delay_q <= delay_q - 17'h0_0001;
               end
            end
            ST_SEND: begin
               if (tx_fire) begin
                  if (idx_q == LAST_CHAR) begin
                     tx_valid_o <= 1'b0;
                     state_q    <= ST_IDLE;
                  end else begin
                     idx_q     <= next_idx;
                     tx_data_o <= char_at(next_idx, id_q, rep_code_q,
                                          rep_val_q);
                  end
               end
            end
            default: begin
               state_q <= ST_IDLE;
            end
         endcase
      end
   end

endmodule : sensor_serial_command_port
`default_nettype wire

/* sensor_cmd_asserts.sv */
// assertions on the outputs of the serial command port
// assumes a bind onto the top module; one clock, sync reset
`timescale 1ns/1ps
`default_nettype none
module sensor_cmd_asserts
   import sensor_cmd_pkg::*;
(
   input wire logic       mclk_i,
   input wire logic       rst_i,
   input wire logic [7:0] tx_data_o,
   input wire logic       tx_valid_o,
   input wire logic       tx_ready_i,
   input wire logic       driver_en_o,
   input wire logic       full_duplex_o,
   input wire logic [1:0] duplex_select_o,
   input wire logic       analog_rx_en_o,
   input wire logic       heat_req_i,
   input wire logic       heat_ctrl_o
);
   default clocking @(posedge mclk_i); endclocking
   default disable iff (rst_i);
   a_reset_values: assert property (disable iff (1'b0)
      $fell(rst_i) |-> full_duplex_o && duplex_select_o == RST_DM)
      else $error("bad duplex after reset");
   a_send_drives: assert property (tx_valid_o |-> driver_en_o)
      else $error("driver off while sending");
   a_p2p_driver: assert property ($past(duplex_select_o) == DM_FULL_P2P
      |-> driver_en_o) else $error("p2p driver off");
   a_driver_drop: assert property ($fell(driver_en_o) |->
      !$past(tx_valid_o) && $past(duplex_select_o) != DM_FULL_P2P)
      else $error("driver dropped early");
   a_hold_reply: assert property (tx_valid_o && !tx_ready_i |=>
      tx_valid_o && $stable(tx_data_o)) else $error("reply byte moved");
   a_full_flag: assert property (full_duplex_o ==
      (duplex_select_o != DM_HALF_BUS)) else $error("duplex flag wrong");
   a_analog_half: assert property (analog_rx_en_o |->
      duplex_select_o == DM_HALF_BUS) else $error("analog rx in full");
   a_heat_follow: assert property (!$past(rst_i, 3) |->
      heat_ctrl_o == $past(heat_req_i, 3)) else $error("heat pin lags");
   c_accept: cover property (tx_valid_o && tx_ready_i);
   c_p2p: cover property (duplex_select_o == DM_FULL_P2P && driver_en_o);
   c_analog: cover property (analog_rx_en_o);
endmodule : sensor_cmd_asserts
bind sensor_serial_command_port sensor_cmd_asserts u_asserts (.*);
`default_nettype wire

/* host_link_model.sv */
// host side of the reply byte handshake, prompt or slow
// assumes the command port's tx handshake on mclk_i
`timescale 1ns/1ps
`default_nettype none
module host_link_model (
   input  wire logic mclk_i,
   input  wire logic slow_i,
   input  wire logic tx_valid_i,
   output var logic  tx_ready_o = 1'b0,
   output var logic  tx_busy_o = 1'b0
);
   logic [1:0] cnt_q = 2'h0;
   // a slow host is ready one cycle in four; busy stands for the stop bit
   always @(posedge mclk_i) begin
      cnt_q <= cnt_q + 2'h1;
      tx_ready_o <= !slow_i || cnt_q == 2'h2;
      tx_busy_o <= tx_valid_i && tx_ready_o;
   end
endmodule : host_link_model
`default_nettype wire

/* test_sensor_serial_command_port.sv */
// self-checking bench of the serial command port
// assumes the host link model; clock and reset are made here
`timescale 1ns/1ps
`default_nettype none
module test_sensor_serial_command_port
   import sensor_cmd_pkg::*;
;
   logic mclk_i = 1'b0, rst_i = 1'b1, rx_valid_i = 1'b0, slow = 1'b0;
   logic heat = 1'b0, tx_valid_o, tx_ready_i, tx_busy_i, driver_en_o;
   logic [7:0] rx_data_i = 8'h00, tx_data_o, q[$];
   logic [19:0] tel_num;
   int mismatches = 0, compares = 0, tels = 0, lat, lats[18];
   string tab[36] = '{"", "!00BR00005!00DM00001",
      "00AV00007", "!00CE00008", "00KY00001", "!00KY00001",
      "00DM00003", "!00CE00016", "00DM00000", "!00DM00000",
      "00AA00001", "!00AA00001", "00DM00002", "!00CE00032",
      "00AA00000", "!00AA00000", "00TT00001", "", "00ID00042", "!42ID00042",
      "00BR", "", "42AV00007", "!42AV00007", "42AV", "!42AV00007",
      "42RD00002", "!42RD00002", "42AV", "!42AV00007", "42TR00004", "",
      "42DM00002", "!42DM00002", "9\r42AV", "!42AV00007"};
   initial forever #10 mclk_i = ~mclk_i;
   sensor_serial_command_port #(.MS_DIV(10), .MINUTE_TICKS(5)) DUT (
      .mclk_i, .rst_i, .rx_data_i, .rx_valid_i, .tx_data_o, .tx_valid_o,
      .tx_ready_i, .tx_busy_i, .tel_busy_i(1'b0), .ext_id_i(8'h00),
      .heat_req_i(heat), .driver_en_o, .full_duplex_o(), .duplex_select_o(),
      .station_id_o(), .access_level_o(), .periodic_en_o(), .data_tel_req_o(),
      .data_tel_num_o(), .analog_rx_en_o(), .heat_ctrl_o());
   host_link_model HOST (.mclk_i, .slow_i(slow), .tx_valid_i(tx_valid_o),
      .tx_ready_o(tx_ready_i), .tx_busy_o(tx_busy_i));
   always @(posedge mclk_i) begin
      heat <= #1 ~heat;
      if (tx_valid_o && tx_ready_i) q.push_back(tx_data_o);
      if (DUT.data_tel_req_o === 1'b1) tels++;
      if (DUT.data_tel_req_o === 1'b1) tel_num = DUT.data_tel_num_o;
   end
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      compares++;
      if (seen !== exp) begin
         mismatches++;
         $display("wrong value at %0t: %h vs %h", $time, seen, exp);
      end
   endtask : chk
   // gaps let the parser return to idle, otherwise bytes are dropped
   task automatic tel(input string cmd, input string rep);
      string s;
      lat = 0;
      q.delete();
      s = {"\r", cmd, "\r"};
      foreach (s[i]) begin
         @(posedge mclk_i) #1 rx_data_i = s[i];
         rx_valid_i = 1'b1;
         @(posedge mclk_i) #1 rx_valid_i = 1'b0;
         repeat (6) @(posedge mclk_i);
      end
      while (q.size() < rep.len() && lat < 3000) begin
         @(posedge mclk_i);
         lat++;
      end
      repeat (rep.len() ? 30 : 300) @(posedge mclk_i);
      chk(q.size(), rep.len());
      foreach (rep[i]) chk(q[i], rep[i]);
   endtask : tel
   task automatic finish_test();
      $display("compares %0d mismatches %0d", compares, mismatches);
      if (mismatches == 0 && compares > 0)
         $display("ALL TESTS PASSED");
      else
         $display("TESTS FAILED");
      $finish;
   endtask : finish_test
   initial begin
      repeat (4) @(posedge mclk_i);
      #1 rst_i = 1'b0;
      for (int i = 0; i < 18; i++) begin
         @(posedge mclk_i) #1 slow = i[0];
         tel(tab[2*i], tab[2*i+1]);
         lats[i] = lat;
      end
      chk(lats[14] - lats[12] >= 10, 1);
      chk(tels, 2);
      chk(tel_num, 20'h0_0004);
      chk(DUT.station_id_o, 8'h42);
      chk(DUT.access_level_o, LVL_USER);
      chk(DUT.periodic_en_o, 1'b1);
      chk(DUT.duplex_select_o, DM_FULL_P2P);
      chk(driver_en_o, 1'b1);
      finish_test();
   end
   initial begin
      #1_000_000;
      mismatches++;
      finish_test();
   end
endmodule : test_sensor_serial_command_port
`default_nettype wire
